/* hdl/sptlb_core.sv */
// small-page translation buffer: control registers, entries and lookup
`timescale 1ns/100ps
module sptlb_core
    import sptlb_pkg::*;
#(
    parameter int ENTRIES = 16,
    parameter bit HAS_1K = 1'b1,
    parameter bit HAS_2K = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cop_wr_en,
    input wire logic cop_rd_en,
    input wire logic [4:0] cop_num,
    input wire logic [2:0] cop_sel,
    input wire logic [31:0] cop_wdata,
    output logic [31:0] cop_rdata,
    output logic cop_rd_valid,
    input wire logic tlb_wr_en,
    input wire logic tlb_rd_en,
    input wire logic [$clog2(ENTRIES)-1:0] tlb_index,
    input wire logic lk_valid,
    input wire sptlb_pkg::sptlb_kind_t lk_kind,
    input wire logic [sptlb_pkg::VA_W-1:0] lk_va,
    output logic lk_done,
    output sptlb_pkg::sptlb_fault_t lk_fault,
    output logic [sptlb_pkg::PA_W-1:0] lk_pa,
    output logic [2:0] lk_cattr
);
    import sptlb_pkg::*;

    // ****************************************
    // state
    // ****************************************
    logic rie_reg, rie_next, xie_reg, xie_next;
    logic [1:0] gmask_reg, gmask_next, gmask_eff, gwr_eff;
    logic [VPN_W-1:0] vpn_reg, vpn_next;
    logic [ADDRESS_SPACE_ID_W-1:0] address_space_id_reg, address_space_id_next;
    logic [PMASK_W-1:0] pmask_reg, pmask_next;
    logic [31:0] even_reg, even_next, odd_reg, odd_next;
    logic [31:0] rdata_next;
    sptlb_entry_t tlb_mem [ENTRIES];
    sptlb_entry_t wr_entry, rd_entry;
    logic lk_done_next;
    sptlb_fault_t lk_fault_next;
    logic [PA_W-1:0] lk_pa_next;
    logic [2:0] lk_cattr_next;

    // unimplemented grain bits: low ones read 1, high ones copy the top implemented bit
    function automatic logic [1:0] grain_fold(input logic [1:0] w);
        logic [1:0] r;
        r = w; // R20
        if (HAS_1K && !HAS_2K) begin
            r = {w[0], w[0]}; // R4 R6
        end else if (!HAS_1K && HAS_2K) begin
            r = {w[1], 1'b1}; // R3 R5
        end else if (!HAS_1K && !HAS_2K) begin
            r = GRAIN_MASK_RESET; // R3
        end
        return r;
    endfunction

    assign gmask_eff = grain_fold(gmask_reg);
    assign gwr_eff = grain_fold(cop_wdata[GRAIN_MASK_HI:GRAIN_MASK_LO]);

    function automatic logic is_reg(input logic [4:0] n, input logic [2:0] s,
                                    input logic [4:0] rn, input logic [2:0] rs);
        return (n == rn) && (s == rs);
    endfunction

    // inhibit bits only stick while their enables are set
    function automatic logic [31:0] lo_filter(input logic [31:0] w, input logic ri_en, input logic xi_en);
        logic [31:0] r;
        r = w;
        r[LO_RI_BIT] = w[LO_RI_BIT] & ri_en; // R23
        r[LO_XI_BIT] = w[LO_XI_BIT] & xi_en; // R23
        return r;
    endfunction

    // ****************************************
    // lookup
    // ****************************************
    logic [ENTRIES-1:0] hit_vec, odd_vec;
    logic any_hit, sel_odd;
    logic [$clog2(ENTRIES)-1:0] hit_idx;
    sptlb_entry_t hit_e;
    logic [31:0] half;
    logic [PMASK_W-1:0] hit_mask;
    logic [PFN_W+1:0] pa_pfn;
    logic [PA_W-1:0] off_mask;
    logic [1:0] va_keep;

    genvar gi;
    generate
        for (gi = 0; gi < ENTRIES; gi++) begin : g_match
            sptlb_entry_match u_match (
                .virtual_page_pair_number(tlb_mem[gi].virtual_page_pair_number),
                .eff_mask(tlb_mem[gi].mask | {{(PMASK_W-2){1'b0}}, gmask_eff}), // R21
                .g(tlb_mem[gi].g),
                .address_space_id(tlb_mem[gi].address_space_id),
                .cur_address_space_id(address_space_id_reg),
                .va(lk_va),
                .hit(hit_vec[gi]),
                .odd_sel(odd_vec[gi])
            );
        end
    endgenerate

    always_comb begin
        any_hit = 1'b0;
        hit_idx = '0;
        for (int i = ENTRIES - 1; i >= 0; i--) begin
            if (hit_vec[i]) begin
                any_hit = 1'b1;
                hit_idx = i[$clog2(ENTRIES)-1:0];
            end
        end
    end

    assign hit_e = tlb_mem[hit_idx];
    assign sel_odd = odd_vec[hit_idx];
    assign half = sel_odd ? hit_e.odd : hit_e.even; // R14 R22
    assign hit_mask = hit_e.mask | {{(PMASK_W-2){1'b0}}, gmask_eff};
    assign off_mask = {{(PA_W-PMASK_W-MIN_OFFSET_W){1'b0}}, hit_mask, MIN_OFFSET_ONES};
    assign va_keep = ~gmask_eff;

    // frame number position moves with the granule: PFN covers PA bits from 10, 11 or 12
    always_comb begin
        unique case (gmask_eff)
            2'b00: pa_pfn = {2'b00, half[LO_PFN_HI:LO_PFN_LO]}; // R18
            2'b01: pa_pfn = {1'b0, half[LO_PFN_HI:LO_PFN_LO], 1'b0}; // R18
            default: pa_pfn = {half[LO_PFN_HI:LO_PFN_LO], 2'b00}; // R18
        endcase
    end

    always_comb begin
        lk_done_next = lk_valid;
        lk_fault_next = SPTLB_OK;
        lk_pa_next = ({pa_pfn, {MIN_OFFSET_W{1'b0}}} & ~off_mask) |
                     ({{(PA_W-VA_W){1'b0}}, lk_va} & off_mask);
        lk_cattr_next = half[LO_C_HI:LO_C_LO];
        if (!any_hit) begin
            lk_fault_next = SPTLB_MISS; // R24
        end else if (!half[LO_V_BIT]) begin
            lk_fault_next = SPTLB_INVALID;
        end else if (half[LO_RI_BIT] && (lk_kind == SPTLB_LOAD)) begin
            lk_fault_next = SPTLB_INVALID; // R17
        end else if (half[LO_XI_BIT] && (lk_kind == SPTLB_FETCH)) begin
            lk_fault_next = SPTLB_INVALID; // R16
        end else if (!half[LO_D_BIT] && (lk_kind == SPTLB_STORE)) begin
            lk_fault_next = SPTLB_MODIFIED; // R24
        end
        if (!lk_valid) begin
            lk_fault_next = lk_fault;
            lk_pa_next = lk_pa;
            lk_cattr_next = lk_cattr;
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    assign rd_entry = tlb_mem[tlb_index];

    always_comb begin
        rie_next = rie_reg;
        xie_next = xie_reg;
        gmask_next = gmask_reg;
        vpn_next = vpn_reg;
        address_space_id_next = address_space_id_reg;
        pmask_next = pmask_reg;
        even_next = even_reg;
        odd_next = odd_reg;
        if (cop_wr_en) begin
            if (is_reg(cop_num, cop_sel, REG_GRAIN_NUM, SEL_GRAIN)) begin
                rie_next = cop_wdata[GRAIN_RIE_BIT]; // R23
                xie_next = cop_wdata[GRAIN_XIE_BIT]; // R23
                gmask_next = gwr_eff; // R5 R6
            end
            if (is_reg(cop_num, cop_sel, REG_MATCH_NUM, SEL_MATCH)) begin
                vpn_next = cop_wdata[MATCH_VPN_HI:MATCH_VPN_LO]; // R7
                vpn_next[1:0] = cop_wdata[GRAIN_MASK_HI:GRAIN_MASK_LO] & ~gmask_eff; // R8
                address_space_id_next = cop_wdata[MATCH_ADDRESS_SPACE_ID_HI:0];
            end
            if (is_reg(cop_num, cop_sel, REG_PMASK_NUM, SEL_PMASK)) begin
                pmask_next = cop_wdata[PMASK_HI:PMASK_LO];
                pmask_next[1:0] = cop_wdata[GRAIN_MASK_HI:GRAIN_MASK_LO] & ~gmask_eff; // R21
            end
            if (is_reg(cop_num, cop_sel, REG_EVEN_NUM, SEL_EVEN)) begin
                even_next = lo_filter(cop_wdata, rie_reg, xie_reg);
            end
            if (is_reg(cop_num, cop_sel, REG_ODD_NUM, SEL_ODD)) begin
                odd_next = lo_filter(cop_wdata, rie_reg, xie_reg);
            end
        end
        // a faulting reference leaves its page pair for the handler; the id register keeps its value
        if (lk_valid && (lk_fault_next != SPTLB_OK)) begin
            vpn_next = lk_va[MATCH_VPN_HI:MATCH_VPN_LO]; // R7
            vpn_next[1:0] = lk_va[GRAIN_MASK_HI:GRAIN_MASK_LO] & va_keep; // R8
        end
        if (tlb_rd_en) begin
            vpn_next = rd_entry.virtual_page_pair_number; // R7
            address_space_id_next = rd_entry.address_space_id;
            pmask_next = rd_entry.mask;
            even_next = rd_entry.even;
            odd_next = rd_entry.odd;
        end
    end

    always_comb begin
        wr_entry.virtual_page_pair_number = vpn_reg;
        wr_entry.mask = pmask_reg;
        wr_entry.g = even_reg[LO_G_BIT] & odd_reg[LO_G_BIT];
        wr_entry.address_space_id = address_space_id_reg;
        wr_entry.even = even_reg; // R15
        wr_entry.odd = odd_reg; // R15
    end

    always_comb begin
        rdata_next = '0; // R2 R10
        if (is_reg(cop_num, cop_sel, REG_GRAIN_NUM, SEL_GRAIN)) begin
            rdata_next[GRAIN_RIE_BIT] = rie_reg;
            rdata_next[GRAIN_XIE_BIT] = xie_reg;
            rdata_next[GRAIN_MASK_HI:GRAIN_MASK_LO] = gmask_eff; // R3 R4
            rdata_next[GRAIN_ONES_HI:GRAIN_ONES_LO] = GRAIN_ONES_VAL; // R1
        end else if (is_reg(cop_num, cop_sel, REG_MATCH_NUM, SEL_MATCH)) begin
            rdata_next[MATCH_VPN_HI:MATCH_VPN_LO] = vpn_reg; // R10
            rdata_next[GRAIN_MASK_HI:GRAIN_MASK_LO] = vpn_reg[1:0] & ~gmask_eff; // R8
            rdata_next[MATCH_ADDRESS_SPACE_ID_HI:0] = address_space_id_reg;
        end else if (is_reg(cop_num, cop_sel, REG_PMASK_NUM, SEL_PMASK)) begin
            rdata_next[PMASK_HI:PMASK_LO] = pmask_reg;
            rdata_next[GRAIN_MASK_HI:GRAIN_MASK_LO] = pmask_reg[1:0] & ~gmask_eff; // R21
        end else if (is_reg(cop_num, cop_sel, REG_EVEN_NUM, SEL_EVEN)) begin
            rdata_next = even_reg;
        end else if (is_reg(cop_num, cop_sel, REG_ODD_NUM, SEL_ODD)) begin
            rdata_next = odd_reg;
        end else if (is_reg(cop_num, cop_sel, REG_CFG3_NUM, SEL_CFG3)) begin
            rdata_next[CFG3_PRESENT_BIT] = 1'b1; // R12
            rdata_next[CFG3_ALT_SP_BIT] = 1'b0; // R13
        end
        if (!cop_rd_en) begin
            rdata_next = cop_rdata;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rie_reg <= 1'b0; // R23
            xie_reg <= 1'b0; // R23
            gmask_reg <= GRAIN_MASK_RESET;
            vpn_reg <= '0; // R9
            address_space_id_reg <= '0;
            pmask_reg <= '0;
            even_reg <= '0;
            odd_reg <= '0;
            cop_rdata <= '0;
            cop_rd_valid <= 1'b0;
            lk_done <= 1'b0;
            lk_fault <= SPTLB_OK;
            lk_pa <= '0;
            lk_cattr <= '0;
            for (int i = 0; i < ENTRIES; i++) begin
                tlb_mem[i] <= '0;
            end
        end else begin
            rie_reg <= rie_next;
            xie_reg <= xie_next;
            gmask_reg <= gmask_next;
            vpn_reg <= vpn_next;
            address_space_id_reg <= address_space_id_next;
            pmask_reg <= pmask_next;
            even_reg <= even_next;
            odd_reg <= odd_next;
            cop_rdata <= rdata_next;
            cop_rd_valid <= cop_rd_en;
            lk_done <= lk_done_next;
            lk_fault <= lk_fault_next;
            lk_pa <= lk_pa_next;
            lk_cattr <= lk_cattr_next;
            if (tlb_wr_en) begin
                tlb_mem[tlb_index] <= wr_entry; // R14
            end
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_GRAIN_ONES: assert property ((cop_rd_en && is_reg(cop_num, cop_sel, REG_GRAIN_NUM, SEL_GRAIN)) // R1
        |=> cop_rd_valid && cop_rdata[GRAIN_ONES_HI:GRAIN_ONES_LO] == GRAIN_ONES_VAL)
        else $error("granularity ones field wrong");
    AST_GRAIN_ZERO: assert property ((cop_rd_en && is_reg(cop_num, cop_sel, REG_GRAIN_NUM, SEL_GRAIN)) // R2
        |=> cop_rdata[29:13] == '0 && cop_rdata[7:0] == '0)
        else $error("granularity reserved bits not zero");
    AST_GRAIN_LOW: assert property (HAS_1K || gmask_eff[0]) // R3
        else $error("missing low grain bit not one");
    AST_GRAIN_HIGH: assert property (HAS_2K || !HAS_1K || gmask_eff[1] == gmask_eff[0]) // R4
        else $error("missing high grain bit not copied");
    AST_MATCH_LOW: assert property ((cop_rd_en && is_reg(cop_num, cop_sel, REG_MATCH_NUM, SEL_MATCH)) // R8
        |=> (cop_rdata[GRAIN_MASK_HI:GRAIN_MASK_LO] & $past(gmask_eff)) == 2'b00
            && cop_rdata[GRAIN_ONES_HI:GRAIN_ONES_LO] == 3'h0)
        else $error("match register masked bits not zero");
    AST_CFG3: assert property ((cop_rd_en && is_reg(cop_num, cop_sel, REG_CFG3_NUM, SEL_CFG3)) // R12
        |=> cop_rdata[CFG3_PRESENT_BIT] && !cop_rdata[CFG3_ALT_SP_BIT])
        else $error("config word three flags wrong");
    AST_FETCH_XI: assert property ((lk_valid && lk_kind == SPTLB_FETCH && any_hit && half[LO_V_BIT] // R16
        && half[LO_XI_BIT]) |=> lk_done && lk_fault == SPTLB_INVALID)
        else $error("execute inhibit fetch not faulted");
    AST_LOAD_RI: assert property ((lk_valid && lk_kind == SPTLB_LOAD && any_hit && half[LO_V_BIT] // R17
        && half[LO_RI_BIT]) |=> lk_done && lk_fault == SPTLB_INVALID)
        else $error("read inhibit load not faulted");
    AST_MISS_LOAD: assert property ((lk_valid && !any_hit && !tlb_rd_en) // R7
        |=> lk_fault == SPTLB_MISS && vpn_reg[VPN_W-1:2] == $past(lk_va[MATCH_VPN_HI:GRAIN_MASK_HI+1]))
        else $error("miss did not load page pair");

    COV_FETCH_OK: cover property (lk_valid && lk_kind == SPTLB_FETCH ##1 lk_fault == SPTLB_OK);
    COV_MISS: cover property (lk_valid ##1 lk_fault == SPTLB_MISS);
    COV_MODIFIED: cover property (lk_valid && lk_kind == SPTLB_STORE ##1 lk_fault == SPTLB_MODIFIED);
    COV_WRITE_HIT: cover property (tlb_wr_en ##1 lk_valid && any_hit);

endmodule

/* hdl/sptlb_entry_match.sv */
// compare one translation entry against a virtual address
`timescale 1ns/100ps
module sptlb_entry_match
    import sptlb_pkg::*;
(
    input wire logic [sptlb_pkg::VPN_W-1:0] virtual_page_pair_number,
    input wire logic [sptlb_pkg::PMASK_W-1:0] eff_mask,
    input wire logic g,
    input wire logic [sptlb_pkg::ADDRESS_SPACE_ID_W-1:0] address_space_id,
    input wire logic [sptlb_pkg::ADDRESS_SPACE_ID_W-1:0] cur_address_space_id,
    input wire logic [sptlb_pkg::VA_W-1:0] va,
    output logic hit,
    output logic odd_sel
);
    logic [VPN_W-1:0] cmp_mask;
    logic [PMASK_W:0] above;
    logic [PMASK_W:0] onehot;

    // mask covers bits 24:11 only; upper page pair bits always compare
    assign cmp_mask = {{(VPN_W-PMASK_W){1'b0}}, eff_mask};
    assign hit = ((virtual_page_pair_number & ~cmp_mask) == (va[VA_W-1:MATCH_VPN_LO] & ~cmp_mask)) &&
                 (g || (address_space_id == cur_address_space_id)); // R19

    // first address bit above the page offset, bit 10 upward (contiguous masks only)
    assign above = {1'b0, eff_mask};
    assign onehot = ~above & {above[PMASK_W-1:0], 1'b1};
    assign odd_sel = |(onehot & va[PMASK_HI:MIN_OFFSET_W]); // R22

endmodule

/* hdl/sptlb_pkg.sv */
// constants, types and register layout for the small-page translation buffer
// Function
// [R1] granularity bits 10:8 always read as ones
// [R2] granularity bits 29:13, 7:0 read zero
// [R3] missing low mask bits read/act as one
// [R4] missing high mask bits copy highest bit
// [R5] 2K-only part: 00,01->01; 10,11->11
// [R6] 1K-only part: 00,10->00; 01,11->11
// [R7] match page pair loaded by hardware/software
// [R8] page pair bits 12:11 zero where masked
// [R9] reset clears page pair bits 12:11
// [R10] match register bits 10:8 read zero
// [R11] match register unpredictable after granularity change
// [R12] config word three bit 1 set
// [R13] alternative small-page flag reads zero
// [R14] entry maps page pair, two halves
// [R15] even half from even, odd from odd
// [R16] fetch with execute inhibit faults invalid
// [R17] load with read inhibit faults invalid
// [R18] granule mask sets page number geometry
// [R19] match on unmasked page pair and id
// [R20] mask 00=1K, 01=2K, 11=4K pages
// [R21] overridden page mask bits read zero
// [R22] half chosen by bit above offset
// [R23] inhibit enables gate inhibit bits, reset zero
// [R24] store on clean page modifies; no match misses
package sptlb_pkg;

    // ****************************************
    // register identities (number, select)
    // ****************************************
    localparam logic [4:0] REG_EVEN_NUM = 5'h02;
    localparam logic [4:0] REG_ODD_NUM = 5'h03;
    localparam logic [4:0] REG_PMASK_NUM = 5'h05;
    localparam logic [4:0] REG_GRAIN_NUM = 5'h05;
    localparam logic [4:0] REG_MATCH_NUM = 5'h0a;
    localparam logic [4:0] REG_CFG3_NUM = 5'h10;
    localparam logic [2:0] SEL_EVEN = 3'h0;
    localparam logic [2:0] SEL_ODD = 3'h0;
    localparam logic [2:0] SEL_PMASK = 3'h0;
    localparam logic [2:0] SEL_GRAIN = 3'h1;
    localparam logic [2:0] SEL_MATCH = 3'h0;
    localparam logic [2:0] SEL_CFG3 = 3'h3;

    // ****************************************
    // field layout
    // ****************************************
    localparam int GRAIN_RIE_BIT = 31;
    localparam int GRAIN_XIE_BIT = 30;
    localparam int GRAIN_MASK_HI = 12;
    localparam int GRAIN_MASK_LO = 11;
    localparam int GRAIN_ONES_HI = 10;
    localparam int GRAIN_ONES_LO = 8;
    localparam logic [2:0] GRAIN_ONES_VAL = 3'h7;
    localparam logic [1:0] GRAIN_MASK_RESET = 2'h3;
    localparam int MATCH_VPN_HI = 31;
    localparam int MATCH_VPN_LO = 11;
    localparam int MATCH_ADDRESS_SPACE_ID_HI = 7;
    localparam int PMASK_HI = 24;
    localparam int PMASK_LO = 11;
    localparam int LO_RI_BIT = 31;
    localparam int LO_XI_BIT = 30;
    localparam int LO_PFN_HI = 29;
    localparam int LO_PFN_LO = 6;
    localparam int LO_C_HI = 5;
    localparam int LO_C_LO = 3;
    localparam int LO_D_BIT = 2;
    localparam int LO_V_BIT = 1;
    localparam int LO_G_BIT = 0;
    localparam int CFG3_PRESENT_BIT = 1;
    localparam int CFG3_ALT_SP_BIT = 4;
    localparam int VA_W = 32;
    localparam int VPN_W = 21;
    localparam int PMASK_W = 14;
    localparam int ADDRESS_SPACE_ID_W = 8;
    localparam int PFN_W = 24;
    localparam int PA_W = 36;
    localparam int MIN_OFFSET_W = 10;
    localparam logic [MIN_OFFSET_W-1:0] MIN_OFFSET_ONES = 10'h3ff;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        SPTLB_FETCH = 2'b00,
        SPTLB_LOAD = 2'b01,
        SPTLB_STORE = 2'b10
    } sptlb_kind_t;

    typedef enum logic [1:0] {
        SPTLB_OK = 2'b00,
        SPTLB_MISS = 2'b01,
        SPTLB_INVALID = 2'b10,
        SPTLB_MODIFIED = 2'b11
    } sptlb_fault_t;

    typedef struct packed {
        logic [VPN_W-1:0] virtual_page_pair_number;
        logic [PMASK_W-1:0] mask;
        logic g;
        logic [ADDRESS_SPACE_ID_W-1:0] address_space_id;
        logic [31:0] even;
        logic [31:0] odd;
    } sptlb_entry_t;

endpackage

/* tb/sptlb_pipe_model.sv */
// pipeline-side model that issues fetch, load and store references
`timescale 1ns/100ps
module sptlb_pipe_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req,
    input wire sptlb_pkg::sptlb_kind_t req_kind,
    input wire logic [31:0] req_va,
    output logic lk_valid,
    output sptlb_pkg::sptlb_kind_t lk_kind,
    output logic [31:0] lk_va
);
    import sptlb_pkg::*;

    // ****************************************
    // reference issue
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lk_valid <= 1'b0;
            lk_kind <= SPTLB_FETCH;
            lk_va <= 32'h0;
        end else if (req) begin
            lk_valid <= 1'b1;
            lk_kind <= req_kind;
            lk_va <= req_va;
        end else begin
            lk_valid <= 1'b0;
            // idle address churns so a stale value never looks like a request
            lk_va <= ~lk_va;
        end
    end
endmodule

/* tb/test_small_page_tlb_translation.sv */
// self-checking bench for the small-page translation buffer
`timescale 1ns/100ps
module test_small_page_tlb_translation;
    import sptlb_pkg::*;

    // ****************************************
    // signals and scoreboard
    // ****************************************
    logic clk, rst_n, cop_wr_en, cop_rd_en, cop_rd_valid, tlb_wr_en, tlb_rd_en, req, lk_valid, lk_done;
    logic [4:0] cop_num;
    logic [2:0] cop_sel;
    logic [31:0] cop_wdata, cop_rdata, req_va, lk_va, er, rdata_2k;
    logic [3:0] tlb_index;
    sptlb_kind_t req_kind, lk_kind;
    sptlb_fault_t lk_fault;
    logic [35:0] lk_pa;
    logic [2:0] lk_cattr;
    logic [41:0] el;
    logic [31:0] q_rd[$];
    logic [41:0] q_lk[$];
    int fails = 0;
    int compares = 0;

    sptlb_core #(.ENTRIES(16), .HAS_1K(1'b1), .HAS_2K(1'b1)) i_dut (
        .clk(clk), .rst_n(rst_n), .cop_wr_en(cop_wr_en), .cop_rd_en(cop_rd_en), .cop_num(cop_num),
        .cop_sel(cop_sel), .cop_wdata(cop_wdata), .cop_rdata(cop_rdata), .cop_rd_valid(cop_rd_valid),
        .tlb_wr_en(tlb_wr_en), .tlb_rd_en(tlb_rd_en), .tlb_index(tlb_index), .lk_valid(lk_valid),
        .lk_kind(lk_kind), .lk_va(lk_va), .lk_done(lk_done), .lk_fault(lk_fault), .lk_pa(lk_pa),
        .lk_cattr(lk_cattr)
    );

    // second copy without 1K grain so the subset folding is exercised
    sptlb_core #(.ENTRIES(16), .HAS_1K(1'b0), .HAS_2K(1'b1)) i_dut_2k (
        .clk(clk), .rst_n(rst_n), .cop_wr_en(cop_wr_en), .cop_rd_en(cop_rd_en), .cop_num(cop_num),
        .cop_sel(cop_sel), .cop_wdata(cop_wdata), .cop_rdata(rdata_2k), .cop_rd_valid(),
        .tlb_wr_en(tlb_wr_en), .tlb_rd_en(tlb_rd_en), .tlb_index(tlb_index), .lk_valid(lk_valid),
        .lk_kind(lk_kind), .lk_va(lk_va), .lk_done(), .lk_fault(), .lk_pa(), .lk_cattr()
    );

    sptlb_pipe_model i_pipe (
        .clk(clk), .rst_n(rst_n), .req(req), .req_kind(req_kind), .req_va(req_va),
        .lk_valid(lk_valid), .lk_kind(lk_kind), .lk_va(lk_va)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] lo(input logic ri, input logic xi, input logic [23:0] pfn,
                                       input logic [2:0] c, input logic d, input logic v);
        return {ri, xi, pfn, c, d, v, 1'b0};
    endfunction

    function automatic logic [35:0] xpa(input logic [23:0] pfn, input logic [31:0] va, input int e);
        logic [35:0] m;
        m = (36'h1 << (10 + e)) - 36'h1;
        return (36'(pfn) << (10 + e)) | (36'(va) & m);
    endfunction

    task automatic check(input logic ok, input string what);
        compares++;
        if (ok !== 1'b1) begin
            fails++;
            $display("[FAIL] %0t %s mismatch", $time, what);
        end
    endtask

    task automatic cop_op(input logic wr, input logic [4:0] n, input logic [2:0] s, input logic [31:0] d);
        @(posedge clk);
        cop_wr_en <= wr;
        cop_rd_en <= !wr;
        cop_num <= n;
        cop_sel <= s;
        cop_wdata <= d;
        @(posedge clk);
        cop_wr_en <= 1'b0;
        cop_rd_en <= 1'b0;
    endtask

    task automatic cop_rd(input logic [4:0] n, input logic [2:0] s, input logic [31:0] x);
        q_rd.push_back(x);
        cop_op(1'b0, n, s, 32'h0);
    endtask

    task automatic tlb_op(input logic wr, input logic [3:0] idx);
        @(posedge clk);
        tlb_wr_en <= wr;
        tlb_rd_en <= !wr;
        tlb_index <= idx;
        @(posedge clk);
        tlb_wr_en <= 1'b0;
        tlb_rd_en <= 1'b0;
    endtask

    task automatic look(input sptlb_kind_t k, input logic [31:0] va, input sptlb_fault_t f,
                        input logic [2:0] c, input logic [35:0] pa, input logic chk);
        q_lk.push_back({chk, f, c, pa});
        @(posedge clk);
        req <= 1'b1;
        req_kind <= k;
        req_va <= va;
        @(posedge clk);
        req <= 1'b0;
    endtask

    // entry 0 made invalid so granularity may change safely
    task automatic flush();
        cop_op(1'b1, REG_EVEN_NUM, SEL_EVEN, 32'h0);
        cop_op(1'b1, REG_ODD_NUM, SEL_ODD, 32'h0);
        tlb_op(1'b1, 4'h0);
    endtask

    task automatic print_verdict();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ****************************************
    // result monitor
    // ****************************************
    always @(negedge clk) begin
        if (cop_rd_valid === 1'b1) begin
            er = (q_rd.size() > 0) ? q_rd.pop_front() : 32'hx;
            check(cop_rdata === er, "register read");
            if (cop_num == REG_GRAIN_NUM && cop_sel == SEL_GRAIN) begin
                check(rdata_2k === {er[31:13], er[12], 1'b1, er[10:0]}, "2k-only grain read");
            end
        end
        if (lk_done === 1'b1) begin
            el = (q_lk.size() > 0) ? q_lk.pop_front() : 42'hx;
            check(lk_fault === el[40:39] && (el[41] === 1'b0 || {lk_cattr, lk_pa} === el[38:0]), "lookup");
        end
    end

    initial begin
        #500_000;
        fails++;
        print_verdict();
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        logic [31:0] va, vm, ve, vo;
        logic [23:0] p0, p1;
        logic [1:0] g;
        {rst_n, cop_wr_en, cop_rd_en, tlb_wr_en, tlb_rd_en, req} = 6'h0;
        {cop_num, cop_sel, cop_wdata, tlb_index, req_va} = 76'h0;
        req_kind = SPTLB_FETCH;
        void'($urandom(32'h5eac999c));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        cop_rd(REG_GRAIN_NUM, SEL_GRAIN, 32'h00001f00);
        cop_rd(REG_CFG3_NUM, SEL_CFG3, 32'h00000002);
        cop_rd(REG_MATCH_NUM, SEL_MATCH, 32'h0);
        cop_rd(5'h1f, 3'h7, 32'h0);
        $display("test reset values done");
        cop_op(1'b1, REG_GRAIN_NUM, SEL_GRAIN, 32'hc0001f00);
        cop_rd(REG_GRAIN_NUM, SEL_GRAIN, 32'hc0001f00);
        cop_op(1'b1, REG_GRAIN_NUM, SEL_GRAIN, 32'h00000700);
        cop_rd(REG_GRAIN_NUM, SEL_GRAIN, 32'h00000700);
        $display("test reserved bits done");
        for (int e = 0; e < 3; e++) begin
            g = (e == 0) ? 2'b00 : (e == 1) ? 2'b01 : 2'b11;
            flush();
            cop_op(1'b1, REG_GRAIN_NUM, SEL_GRAIN, {2'b11, 17'h0, g, 3'h7, 8'h0});
            cop_rd(REG_GRAIN_NUM, SEL_GRAIN, {2'b11, 17'h0, g, 3'h7, 8'h0});
            va = $urandom;
            p0 = 24'($urandom);
            p1 = 24'($urandom);
            cop_op(1'b1, REG_MATCH_NUM, SEL_MATCH, {va[31:11], 3'h0, 8'h12});
            cop_rd(REG_MATCH_NUM, SEL_MATCH, {va[31:13], va[12:11] & ~g, 3'h0, 8'h12});
            cop_op(1'b1, REG_PMASK_NUM, SEL_PMASK, 32'h0);
            cop_op(1'b1, REG_EVEN_NUM, SEL_EVEN, lo(1'b0, 1'b1, p0, 3'h3, 1'b1, 1'b1));
            cop_op(1'b1, REG_ODD_NUM, SEL_ODD, lo(1'b1, 1'b0, p1, 3'h5, 1'b0, 1'b1));
            tlb_op(1'b1, 4'h0);
            ve = va & ~(32'h1 << (10 + e));
            vo = va | (32'h1 << (10 + e));
            look(SPTLB_LOAD, ve, SPTLB_OK, 3'h3, xpa(p0, ve, e), 1'b1);
            look(SPTLB_FETCH, ve, SPTLB_INVALID, 3'h0, 36'h0, 1'b0);
            look(SPTLB_STORE, ve, SPTLB_OK, 3'h3, xpa(p0, ve, e), 1'b1);
            look(SPTLB_FETCH, vo, SPTLB_OK, 3'h5, xpa(p1, vo, e), 1'b1);
            look(SPTLB_LOAD, vo, SPTLB_INVALID, 3'h0, 36'h0, 1'b0);
            look(SPTLB_STORE, vo, SPTLB_MODIFIED, 3'h0, 36'h0, 1'b0);
            vm = va ^ 32'h80000000;
            look(SPTLB_LOAD, vm, SPTLB_MISS, 3'h0, 36'h0, 1'b0);
            cop_rd(REG_MATCH_NUM, SEL_MATCH, {vm[31:13], vm[12:11] & ~g, 3'h0, 8'h12});
            tlb_op(1'b0, 4'h0);
            cop_rd(REG_MATCH_NUM, SEL_MATCH, {va[31:13], va[12:11] & ~g, 3'h0, 8'h12});
        end
        $display("test granularity lookups done");
        flush();
        cop_op(1'b1, REG_GRAIN_NUM, SEL_GRAIN, 32'h00001f00);
        cop_op(1'b1, REG_MATCH_NUM, SEL_MATCH, {va[31:11], 3'h0, 8'h12});
        cop_op(1'b1, REG_EVEN_NUM, SEL_EVEN, lo(1'b1, 1'b1, p0, 3'h2, 1'b1, 1'b1));
        cop_rd(REG_EVEN_NUM, SEL_EVEN, lo(1'b0, 1'b0, p0, 3'h2, 1'b1, 1'b1));
        tlb_op(1'b1, 4'h0);
        ve = va & ~32'h1000;
        look(SPTLB_LOAD, ve, SPTLB_OK, 3'h2, xpa(p0, ve, 2), 1'b1);
        look(SPTLB_FETCH, ve, SPTLB_OK, 3'h2, xpa(p0, ve, 2), 1'b1);
        $display("test inhibit enables done");
        repeat (10) @(posedge clk);
        check(q_rd.size() == 0 && q_lk.size() == 0, "pending results");
        print_verdict();
    end
endmodule
